//--- rtl/pbsc_defs.svh
// Purpose: shared constants of the pipelined burst sram core and its master
// Assumes: included by bare name
// Notes: latency is counted in qualified clock edges
`ifndef PBSC_DEFS_SVH
`define PBSC_DEFS_SVH
`define PBSC_DW36 36
`define PBSC_NL36 4
`define PBSC_AW36 21
`define PBSC_DW18 18
`define PBSC_NL18 2
`define PBSC_AW18 22
`define PBSC_LAT 2
`define PBSC_MAX_MHZ 250
`define PBSC_CLK_MHZ 100
`define PBSC_FIFO_DEPTH 4
`define PBSC_IR_W 3
`define PBSC_IR_IDCODE 3'h1
`define PBSC_IR_BYPASS 3'h7
`define PBSC_IR_CAPTURE 3'h1
`define PBSC_ID_W 32
`endif

//--- rtl/pbsc_pkg.sv
// Purpose: types of the pipelined burst sram core
// Assumes: nothing
// Notes: all tap codes are legal
package pbsc_pkg;
  typedef enum logic [1:0] {
    pbsc_op_idle = 2'b00,
    pbsc_op_read = 2'b01,
    pbsc_op_write = 2'b10
  } pbsc_op_e;
  typedef enum logic [3:0] {
    tap_reset = 4'b0000, tap_idle = 4'b0001, tap_sel_dr = 4'b0010,
    tap_cap_dr = 4'b0011, tap_sh_dr = 4'b0100, tap_ex1_dr = 4'b0101,
    tap_pa_dr = 4'b0110, tap_ex2_dr = 4'b0111, tap_up_dr = 4'b1000,
    tap_sel_ir = 4'b1001, tap_cap_ir = 4'b1010, tap_sh_ir = 4'b1011,
    tap_ex1_ir = 4'b1100, tap_pa_ir = 4'b1101, tap_ex2_ir = 4'b1110,
    tap_up_ir = 4'b1111
  } pbsc_tap_e;
endpackage

//--- rtl/pbsc_if.sv
// Purpose: pin bundle between the sram core and its bus master
// Assumes: both ends on one clock
// Notes: resolves the shared data wire from the two output enables
`timescale 1ns/100ps
interface pbsc_if #(
  parameter int DW = 36,
  parameter int NL = 4,
  parameter int AW = 21
);
  logic [AW-1:0] addr;
  logic adv_load;
  logic write_n;
  logic [NL-1:0] byte_lane_write_sel_n;
  logic chip_select_low_first_n;
  logic chip_select_high;
  logic chip_select_low_second_n;
  logic clock_qualify_n;
  logic sleep_request;
  logic out_enable_n;
  logic burst_interleave;
  logic [DW-1:0] host_dq;
  logic host_dq_oe;
  logic [DW-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DW-1:0] dq;
  logic tap_tck;
  logic tap_tms;
  logic tap_tdi;
  logic tap_tdo;
  logic tap_tdo_oe;
  // an undriven wire reads as zero here
  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);
  modport dev (
    input addr, adv_load, write_n, byte_lane_write_sel_n,
    input chip_select_low_first_n, chip_select_high,
    input chip_select_low_second_n, clock_qualify_n, sleep_request,
    input out_enable_n, burst_interleave, dq, tap_tck, tap_tms, tap_tdi,
    output dev_dq, dev_dq_oe, tap_tdo, tap_tdo_oe
  );
  modport host (
    output addr, adv_load, write_n, byte_lane_write_sel_n,
    output chip_select_low_first_n, chip_select_high,
    output chip_select_low_second_n, clock_qualify_n, sleep_request,
    output out_enable_n, burst_interleave, host_dq, host_dq_oe,
    output tap_tck, tap_tms, tap_tdi,
    input dq, tap_tdo
  );
endinterface // pbsc_if

//--- rtl/pbsc_core.sv
// Purpose: pipelined burst sram core, device end of pbsc_if
// Assumes: master on the same clock, pins change right after rising edges
// Notes: read and write data both sit two qualified edges after request
// How it works
// - all inputs but output enable captured at rising clock edge
// - read data leaves through output register
// - deasserted qualify freezes every stage
// - write request plus per-lane selects
// - writes finish internally, no extra strobes
// - three chip selects, async output enable
// - outputs off during write data cycle
// - any read/write mix, no dead cycles
// - burst order linear or interleaved
// - sleep input, clock may stop, data kept
// - 2M x36 or 4M x18 array
// - boundary-scan style test access port
`timescale 1ns/100ps
`include "pbsc_defs.svh"
module pbsc_core #(
  parameter int DW = `PBSC_DW36,
  parameter int NL = `PBSC_NL36,
  parameter int AW = `PBSC_AW36,
  parameter int MEM_AW = `PBSC_AW36,
  parameter logic [31:0] ID_CODE = 32'h0000_0001 // value is arbitrary
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  output logic o_asleep,
  pbsc_if.dev bus
);
  localparam int LW = DW / NL;

  // ************************************
  // input registers
  // ************************************
  logic en;
  logic in_adv_r, in_wr_r, in_sel_r, in_zz_r, in_ilv_r;
  logic [AW-1:0] in_addr_r;
  logic [NL-1:0] in_bw_r;

  assign en = ~bus.clock_qualify_n;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_adv_r <= 1'b0;
      in_wr_r <= 1'b0;
      in_sel_r <= 1'b0;
      in_zz_r <= 1'b0;
      in_ilv_r <= 1'b0;
      in_addr_r <= '0;
      in_bw_r <= '0;
    end else if (en) begin
      in_adv_r <= bus.adv_load;
      in_wr_r <= ~bus.write_n;
      in_sel_r <= ~bus.chip_select_low_first_n & bus.chip_select_high &
                  ~bus.chip_select_low_second_n;
      in_zz_r <= bus.sleep_request;
      in_ilv_r <= bus.burst_interleave;
      in_addr_r <= bus.addr;
      in_bw_r <= ~bus.byte_lane_write_sel_n;
    end
  end

  // ************************************
  // burst decode
  // ************************************
  logic bst_act_r, bst_wr_r;
  logic [AW-1:0] bst_base_r;
  logic [1:0] bst_cnt_r;
  logic [1:0] cnt_nxt;
  logic [AW-1:0] base;
  logic [AW-1:0] addr_nxt;
  pbsc_pkg::pbsc_op_e op_nxt;

  always_comb begin
    cnt_nxt = bst_cnt_r;
    op_nxt = pbsc_pkg::pbsc_op_idle;
    base = in_adv_r ? bst_base_r : in_addr_r;
    if (in_zz_r) begin
      op_nxt = pbsc_pkg::pbsc_op_idle;
    end else if (in_adv_r) begin
      if (bst_act_r) begin
        cnt_nxt = bst_cnt_r + 2'h1;
        op_nxt = bst_wr_r ? pbsc_pkg::pbsc_op_write : pbsc_pkg::pbsc_op_read;
      end
    end else if (in_sel_r) begin
      cnt_nxt = 2'h0;
      op_nxt = in_wr_r ? pbsc_pkg::pbsc_op_write : pbsc_pkg::pbsc_op_read;
    end
    // 2-bit add wraps inside the group of four by itself
    addr_nxt = {base[AW-1:2],
                in_ilv_r ? (base[1:0] ^ cnt_nxt)
                         : (base[1:0] + cnt_nxt)};
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bst_act_r <= 1'b0;
      bst_wr_r <= 1'b0;
      bst_base_r <= '0;
      bst_cnt_r <= 2'h0;
    end else if (en) begin
      bst_act_r <= (op_nxt != pbsc_pkg::pbsc_op_idle);
      bst_cnt_r <= cnt_nxt;
      if (!in_adv_r && in_sel_r && !in_zz_r) begin
        bst_base_r <= in_addr_r;
        bst_wr_r <= in_wr_r;
      end
    end
  end

  // ************************************
  // access pipeline
  // ************************************
  pbsc_pkg::pbsc_op_e b_op_r;
  logic [AW-1:0] b_addr_r, c_addr_r, d_addr_r;
  logic [NL-1:0] b_bw_r, c_bw_r, d_bw_r;
  logic c_wr_r, d_wr_r;
  logic [DW-1:0] din_r;

  // stage b: request at edge k+1, c: k+2, d plus write data: k+3
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      b_op_r <= pbsc_pkg::pbsc_op_idle;
      b_addr_r <= '0;
      b_bw_r <= '0;
      c_wr_r <= 1'b0;
      c_addr_r <= '0;
      c_bw_r <= '0;
      d_wr_r <= 1'b0;
      d_addr_r <= '0;
      d_bw_r <= '0;
      din_r <= '0;
    end else if (en) begin
      b_op_r <= op_nxt;
      b_addr_r <= addr_nxt;
      b_bw_r <= in_bw_r;
      c_wr_r <= (b_op_r == pbsc_pkg::pbsc_op_write);
      c_addr_r <= b_addr_r;
      c_bw_r <= b_bw_r;
      d_wr_r <= c_wr_r;
      d_addr_r <= c_addr_r;
      d_bw_r <= c_bw_r;
      din_r <= bus.dq;
    end
  end

  // ************************************
  // storage array
  // ************************************
  // no reset: contents survive sleep and a stopped clock
  logic [DW-1:0] mem [0:(1 << MEM_AW)-1];

  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w,
    input logic [NL-1:0] sel
  );
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < NL; i++) begin
      if (sel[i]) begin
        res[i*LW +: LW] = new_w[i*LW +: LW];
      end
    end
    return res;
  endfunction

  always_ff @(posedge i_clk) begin
    if (en && d_wr_r) begin
      mem[d_addr_r[MEM_AW-1:0]] <=
        lane_merge(mem[d_addr_r[MEM_AW-1:0]], din_r, d_bw_r);
    end
  end

  // ************************************
  // read path and output register
  // ************************************
  logic [DW-1:0] rd_word;
  logic [DW-1:0] dout_r;
  logic oe_r;

  // forwarding keeps reads right behind writes free of dead cycles
  always_comb begin
    rd_word = mem[b_addr_r[MEM_AW-1:0]];
    if (d_wr_r && d_addr_r == b_addr_r) begin
      rd_word = lane_merge(rd_word, din_r, d_bw_r);
    end
    if (c_wr_r && c_addr_r == b_addr_r) begin
      rd_word = lane_merge(rd_word, bus.dq, c_bw_r);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dout_r <= '0;
      oe_r <= 1'b0;
    end else if (en) begin
      oe_r <= (b_op_r == pbsc_pkg::pbsc_op_read);
      if (b_op_r == pbsc_pkg::pbsc_op_read) begin
        dout_r <= rd_word;
      end
    end
  end

  assign bus.dev_dq = dout_r;
  assign bus.dev_dq_oe = oe_r & ~bus.out_enable_n & ~in_zz_r;
  assign o_asleep = in_zz_r;

  // ************************************
  // test access port
  // ************************************
  logic [2:0] tck_s_r, tms_s_r, tdi_s_r;
  logic tck_rise, tck_fall, tms, tdi;
  pbsc_pkg::pbsc_tap_e ts_r, ts_nxt;
  logic [`PBSC_IR_W-1:0] ir_sh_r, ir_r;
  logic [`PBSC_ID_W-1:0] dr_sh_r;
  logic tdo_r, tdo_oe_r;

  // bit 0 is the first synchroniser stage, read only by bit 1
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tck_s_r <= 3'h0;
      tms_s_r <= 3'h7;
      tdi_s_r <= 3'h0;
    end else begin
      tck_s_r <= {tck_s_r[1:0], bus.tap_tck};
      tms_s_r <= {tms_s_r[1:0], bus.tap_tms};
      tdi_s_r <= {tdi_s_r[1:0], bus.tap_tdi};
    end
  end

  assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
  assign tck_fall = ~tck_s_r[1] & tck_s_r[2];
  assign tms = tms_s_r[2];
  assign tdi = tdi_s_r[2];

  always_comb begin
    unique case (ts_r)
      pbsc_pkg::tap_reset: ts_nxt = tms ? pbsc_pkg::tap_reset : pbsc_pkg::tap_idle;
      pbsc_pkg::tap_idle: ts_nxt = tms ? pbsc_pkg::tap_sel_dr : pbsc_pkg::tap_idle;
      pbsc_pkg::tap_sel_dr: ts_nxt = tms ? pbsc_pkg::tap_sel_ir : pbsc_pkg::tap_cap_dr;
      pbsc_pkg::tap_cap_dr: ts_nxt = tms ? pbsc_pkg::tap_ex1_dr : pbsc_pkg::tap_sh_dr;
      pbsc_pkg::tap_sh_dr: ts_nxt = tms ? pbsc_pkg::tap_ex1_dr : pbsc_pkg::tap_sh_dr;
      pbsc_pkg::tap_ex1_dr: ts_nxt = tms ? pbsc_pkg::tap_up_dr : pbsc_pkg::tap_pa_dr;
      pbsc_pkg::tap_pa_dr: ts_nxt = tms ? pbsc_pkg::tap_ex2_dr : pbsc_pkg::tap_pa_dr;
      pbsc_pkg::tap_ex2_dr: ts_nxt = tms ? pbsc_pkg::tap_up_dr : pbsc_pkg::tap_sh_dr;
      pbsc_pkg::tap_up_dr: ts_nxt = tms ? pbsc_pkg::tap_sel_dr : pbsc_pkg::tap_idle;
      pbsc_pkg::tap_sel_ir: ts_nxt = tms ? pbsc_pkg::tap_reset : pbsc_pkg::tap_cap_ir;
      pbsc_pkg::tap_cap_ir: ts_nxt = tms ? pbsc_pkg::tap_ex1_ir : pbsc_pkg::tap_sh_ir;
      pbsc_pkg::tap_sh_ir: ts_nxt = tms ? pbsc_pkg::tap_ex1_ir : pbsc_pkg::tap_sh_ir;
      pbsc_pkg::tap_ex1_ir: ts_nxt = tms ? pbsc_pkg::tap_up_ir : pbsc_pkg::tap_pa_ir;
      pbsc_pkg::tap_pa_ir: ts_nxt = tms ? pbsc_pkg::tap_ex2_ir : pbsc_pkg::tap_pa_ir;
      pbsc_pkg::tap_ex2_ir: ts_nxt = tms ? pbsc_pkg::tap_up_ir : pbsc_pkg::tap_sh_ir;
      pbsc_pkg::tap_up_ir: ts_nxt = tms ? pbsc_pkg::tap_sel_dr : pbsc_pkg::tap_idle;
    endcase
  end

  // no boundary cells: every code but the id code acts as bypass
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ts_r <= pbsc_pkg::tap_reset;
      ir_sh_r <= '0;
      ir_r <= `PBSC_IR_IDCODE;
      dr_sh_r <= '0;
    end else if (tck_rise) begin
      ts_r <= ts_nxt;
      unique case (ts_r)
        pbsc_pkg::tap_reset: ir_r <= `PBSC_IR_IDCODE;
        pbsc_pkg::tap_cap_ir: ir_sh_r <= `PBSC_IR_CAPTURE;
        pbsc_pkg::tap_sh_ir: ir_sh_r <= {tdi, ir_sh_r[`PBSC_IR_W-1:1]};
        pbsc_pkg::tap_up_ir: ir_r <= ir_sh_r;
        pbsc_pkg::tap_cap_dr: dr_sh_r <= (ir_r == `PBSC_IR_IDCODE) ? ID_CODE : '0;
        pbsc_pkg::tap_sh_dr: begin
          if (ir_r == `PBSC_IR_IDCODE) begin
            dr_sh_r <= {tdi, dr_sh_r[`PBSC_ID_W-1:1]};
          end else begin
            dr_sh_r[0] <= tdi;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= (ts_r == pbsc_pkg::tap_sh_ir) ? ir_sh_r[0] : dr_sh_r[0];
      tdo_oe_r <= (ts_r == pbsc_pkg::tap_sh_ir) ||
                  (ts_r == pbsc_pkg::tap_sh_dr);
    end
  end

  assign bus.tap_tdo = tdo_r;
  assign bus.tap_tdo_oe = tdo_oe_r;
endmodule // pbsc_core

//--- rtl/pbsc_master.sv
// Purpose: bus master end of pbsc_if with a read data fifo
// Assumes: core on the same clock with two-edge latency
// Notes: a full fifo stalls the core through the clock qualify pin
`timescale 1ns/100ps
`include "pbsc_defs.svh"
module pbsc_fifo #(
  parameter int W = `PBSC_DW36,
  parameter int D = `PBSC_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [0:D-1];
  logic [PW-1:0] wp_r, rp_r;
  logic [PW:0] cnt_r;
  logic push, pop;

  assign o_in_ready = (cnt_r != (PW+1)'(D));
  assign o_out_valid = (cnt_r != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem[rp_r];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // pbsc_fifo

module pbsc_master #(
  parameter int DW = `PBSC_DW36,
  parameter int NL = `PBSC_NL36,
  parameter int AW = `PBSC_AW36,
  parameter int FIFO_DEPTH = `PBSC_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic i_req_burst,
  input wire logic [AW-1:0] i_req_addr,
  input wire logic [NL-1:0] i_req_lanes,
  input wire logic [DW-1:0] i_req_wdata,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [DW-1:0] o_rd_data,
  input wire logic i_sleep,
  input wire logic i_out_disable,
  input wire logic i_burst_interleave,
  input wire logic i_tap_tck,
  input wire logic i_tap_tms,
  input wire logic i_tap_tdi,
  output logic o_tap_tdo,
  pbsc_if.host bus
);
  // issue flop plus latency plus the data slot itself
  localparam int PL = `PBSC_LAT + 2;

  // ************************************
  // stall and issue
  // ************************************
  logic en, fifo_in_ready, is_wr, bst_wr_r;
  logic [PL-1:0] rsh_r, wsh_r;
  logic [DW-1:0] wd_r [0:PL-1];
  logic [AW-1:0] addr_r;
  logic adv_r, we_n_r, sel_r;
  logic [NL-1:0] bw_n_r;
  logic zz_r, oe_dis_r, ilv_r, tck_r, tms_r, tdi_r, tdo_r;

  assign en = ~(rsh_r[PL-1] & ~fifo_in_ready);
  assign o_req_ready = en;
  assign bus.clock_qualify_n = ~en;
  assign is_wr = i_req_burst ? bst_wr_r : i_req_write;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_r <= '0;
      adv_r <= 1'b0;
      we_n_r <= 1'b1;
      sel_r <= 1'b0;
      bw_n_r <= '1;
      bst_wr_r <= 1'b0;
    end else if (en) begin
      adv_r <= i_req_valid & i_req_burst;
      sel_r <= i_req_valid;
      if (i_req_valid) begin
        addr_r <= i_req_addr;
        we_n_r <= ~is_wr;
        bw_n_r <= is_wr ? ~i_req_lanes : '1;
        if (!i_req_burst) begin
          bst_wr_r <= i_req_write;
        end
      end else begin
        we_n_r <= 1'b1;
        bw_n_r <= '1;
      end
    end
  end

  // write data follows its request by the same latency as read data
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsh_r <= '0;
      wsh_r <= '0;
      for (int i = 0; i < PL; i++) begin
        wd_r[i] <= '0;
      end
    end else if (en) begin
      rsh_r <= {rsh_r[PL-2:0], i_req_valid & ~is_wr};
      wsh_r <= {wsh_r[PL-2:0], i_req_valid & is_wr};
      wd_r[0] <= i_req_wdata;
      for (int i = 1; i < PL; i++) begin
        wd_r[i] <= wd_r[i-1];
      end
    end
  end

  // ************************************
  // static pins and test port
  // ************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      zz_r <= 1'b0;
      oe_dis_r <= 1'b0;
      ilv_r <= 1'b0;
      tck_r <= 1'b0;
      tms_r <= 1'b1;
      tdi_r <= 1'b0;
      tdo_r <= 1'b0;
    end else begin
      zz_r <= i_sleep;
      oe_dis_r <= i_out_disable;
      ilv_r <= i_burst_interleave;
      tck_r <= i_tap_tck;
      tms_r <= i_tap_tms;
      tdi_r <= i_tap_tdi;
      tdo_r <= bus.tap_tdo;
    end
  end

  assign bus.addr = addr_r;
  assign bus.adv_load = adv_r;
  assign bus.write_n = we_n_r;
  assign bus.byte_lane_write_sel_n = bw_n_r;
  assign bus.chip_select_low_first_n = ~sel_r;
  assign bus.chip_select_high = sel_r;
  assign bus.chip_select_low_second_n = ~sel_r;
  assign bus.sleep_request = zz_r;
  assign bus.out_enable_n = oe_dis_r;
  assign bus.burst_interleave = ilv_r;
  assign bus.host_dq = wd_r[PL-1];
  assign bus.host_dq_oe = wsh_r[PL-1];
  assign bus.tap_tck = tck_r;
  assign bus.tap_tms = tms_r;
  assign bus.tap_tdi = tdi_r;
  assign o_tap_tdo = tdo_r;

  // ************************************
  // read data buffer
  // ************************************
  pbsc_fifo #(
    .W(DW),
    .D(FIFO_DEPTH)
  ) u_rd_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_in_valid(rsh_r[PL-1]),
    .o_in_ready(fifo_in_ready),
    .i_in_data(bus.dq),
    .o_out_valid(o_rd_valid),
    .i_out_ready(i_rd_ready),
    .o_out_data(o_rd_data)
  );
endmodule // pbsc_master

//--- verification/pbsc_monitor.sv
// Purpose: pin-level checks on the link between sram core and master
// Assumes: one clock, latency of two qualified edges
// Notes: watches only what the two design ends drive
`timescale 1ns/100ps
module pbsc_monitor #(
  parameter int DW = 36
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic adv_load,
  input wire logic write_n,
  input wire logic chip_select_low_first_n,
  input wire logic chip_select_high,
  input wire logic chip_select_low_second_n,
  input wire logic clock_qualify_n,
  input wire logic sleep_request,
  input wire logic out_enable_n,
  input wire logic host_dq_oe,
  input wire logic [DW-1:0] host_dq,
  input wire logic dev_dq_oe,
  input wire logic [DW-1:0] dev_dq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic sel;
  logic go;
  assign sel = !chip_select_low_first_n && chip_select_high &&
               !chip_select_low_second_n;
  // a qualified edge while awake; sleep lags one edge inside the core
  assign go = !clock_qualify_n && !sleep_request;
  sequence wr_take;
    go && !adv_load && sel && !write_n;
  endsequence
  sequence rd_take;
    go && !adv_load && sel && write_n;
  endsequence
  a_write_turn: assert property (
    wr_take ##1 go [*2] |-> ##1 (host_dq_oe && !dev_dq_oe))
    else $error("write data slot not owned by master");
  a_read_data: assert property (
    rd_take ##1 go [*2] ##1 (!out_enable_n && !sleep_request)
    |-> dev_dq_oe && !host_dq_oe)
    else $error("read data slot not driven by core");
  a_desel_quiet: assert property (
    (!clock_qualify_n && !adv_load && !sel) ##1 !clock_qualify_n [*2]
    |-> ##1 (!dev_dq_oe && !host_dq_oe))
    else $error("deselected slot carried data");
  a_stall_core: assert property (
    clock_qualify_n |=> $stable(dev_dq))
    else $error("core output moved on ignored edge");
  a_stall_host: assert property (
    clock_qualify_n |=> $stable(host_dq) && $stable(host_dq_oe))
    else $error("master data moved on ignored edge");
  a_no_fight: assert property (
    !(dev_dq_oe && host_dq_oe))
    else $error("both ends drive the data wire");
  a_oe_gate: assert property (
    out_enable_n |-> !dev_dq_oe)
    else $error("core drives while output disabled");
  a_sleep_quiet: assert property (
    (sleep_request && !clock_qualify_n) |=> !dev_dq_oe)
    else $error("core drives while asleep");
  cover property (wr_take);
  cover property (rd_take);
  cover property (clock_qualify_n [*3]);
  cover property (sleep_request [*3]);
endmodule // pbsc_monitor

//--- verification/tb.sv
// Purpose: self-checking bench, core and master face to face
// Assumes: core array shortened to 256 words
// Notes: read words are collected in a queue and judged in order
`timescale 1ns/100ps
`include "pbsc_defs.svh"
module tb;
  localparam int DW = `PBSC_DW36;
  localparam int NL = `PBSC_NL36;
  localparam int AW = `PBSC_AW36;
  localparam int LW = DW / NL;
  localparam logic [31:0] ID = 32'h0a5c_3e71; // value is arbitrary
  logic clk, rstn, req_valid, req_ready, req_write, req_burst, rd_valid;
  logic rd_ready, sleep, out_disable, interleave, tdo, asleep;
  logic tck, tms, tdi;
  logic [AW-1:0] req_addr;
  logic [NL-1:0] req_lanes;
  logic [DW-1:0] req_wdata, rd_data;
  logic [DW-1:0] got_q[$];
  int error_cnt = 0;
  int samples_checked = 0;
  pbsc_if #(.DW(DW), .NL(NL), .AW(AW)) pbsc_bus ();
  pbsc_core #(.MEM_AW(8), .ID_CODE(ID)) i_pbsc_core (.i_clk(clk),
    .i_rstn(rstn),
    .o_asleep(asleep), .bus(pbsc_bus));
  pbsc_master i_pbsc_master (.i_clk(clk), .i_rstn(rstn),
    .i_req_valid(req_valid), .o_req_ready(req_ready),
    .i_req_write(req_write), .i_req_burst(req_burst),
    .i_req_addr(req_addr), .i_req_lanes(req_lanes),
    .i_req_wdata(req_wdata), .o_rd_valid(rd_valid),
    .i_rd_ready(rd_ready), .o_rd_data(rd_data), .i_sleep(sleep),
    .i_out_disable(out_disable), .i_burst_interleave(interleave),
    .i_tap_tck(tck), .i_tap_tms(tms), .i_tap_tdi(tdi),
    .o_tap_tdo(tdo), .bus(pbsc_bus));
  pbsc_monitor #(.DW(DW)) i_pbsc_monitor (.i_clk(clk), .i_rstn(rstn),
    .adv_load(pbsc_bus.adv_load), .write_n(pbsc_bus.write_n),
    .chip_select_low_first_n(pbsc_bus.chip_select_low_first_n),
    .chip_select_high(pbsc_bus.chip_select_high),
    .chip_select_low_second_n(pbsc_bus.chip_select_low_second_n),
    .clock_qualify_n(pbsc_bus.clock_qualify_n),
    .sleep_request(pbsc_bus.sleep_request),
    .out_enable_n(pbsc_bus.out_enable_n),
    .host_dq_oe(pbsc_bus.host_dq_oe), .host_dq(pbsc_bus.host_dq),
    .dev_dq_oe(pbsc_bus.dev_dq_oe), .dev_dq(pbsc_bus.dev_dq));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) got_q.push_back(rd_data);
  end
  function automatic logic [DW-1:0] pat(input logic [8:0] n);
    return {n ^ 9'h1c3, n ^ 9'h0a5, n ^ 9'h15a, n};
  endfunction
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] e);
    samples_checked++;
    if (seen !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, e);
    end
  endtask
  task automatic req(input logic w, input logic b, input logic [AW-1:0] a,
                     input logic [NL-1:0] l, input logic [DW-1:0] d);
    int n;
    req_valid <= 1'b1;
    req_write <= w;
    req_burst <= b;
    req_addr <= a;
    req_lanes <= l;
    req_wdata <= d;
    n = 0;
    // ready is combinational, so it is read where it has settled
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    @(posedge clk);
    if (n >= 300) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic idle(input int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic expect_rd(input logic [DW-1:0] e);
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (got_q.size() == 0) begin
      check('x, e);
      complete_run();
    end else begin
      check(got_q.pop_front(), e);
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_b2b();
    for (int i = 0; i < 4; i++) req(1'b1, 1'b0, AW'(i), '1, pat(9'(i)));
    for (int i = 0; i < 4; i++) req(1'b0, 1'b0, AW'(i), '0, '0);
    req(1'b1, 1'b0, AW'(2), '1, pat(9'h55));
    req(1'b0, 1'b0, AW'(2), '0, '0);
    idle(1);
    for (int i = 0; i < 4; i++) expect_rd(pat(9'(i)));
    expect_rd(pat(9'h55));
  endtask
  task automatic t_lanes();
    logic [DW-1:0] e;
    for (int i = 0; i < NL; i++) begin
      req(1'b1, 1'b0, AW'(16), '1, pat(9'h1));
      req(1'b1, 1'b0, AW'(16), NL'(1 << i), '0);
      req(1'b0, 1'b0, AW'(16), '0, '0);
      idle(1);
      e = pat(9'h1);
      e[i*LW +: LW] = '0;
      expect_rd(e);
    end
  endtask
  task automatic t_burst(input logic ilv);
    logic [1:0] lo;
    interleave <= ilv;
    idle(3);
    req(1'b1, 1'b0, AW'(8'h25), '1, pat(9'h0));
    for (int c = 1; c < 4; c++) req(1'b1, 1'b1, '0, '1, pat(9'(c)));
    for (int c = 0; c < 4; c++) begin
      lo = ilv ? (2'b01 ^ 2'(c)) : (2'b01 + 2'(c));
      req(1'b0, 1'b0, AW'({6'h09, lo}), '0, '0);
    end
    idle(1);
    for (int c = 0; c < 4; c++) expect_rd(pat(9'(c)));
  endtask
  task automatic t_stall();
    rd_ready <= 1'b0;
    fork
      begin
        for (int i = 0; i < 6; i++) req(1'b0, 1'b0, AW'(i % 2), '0, '0);
        // stop issuing, or extra reads would leak into later scenarios
        req_valid <= 1'b0;
      end
      begin
        repeat (30) @(posedge clk);
        check(DW'(req_ready), '0);
        check(DW'(pbsc_bus.clock_qualify_n), DW'(1));
        rd_ready <= 1'b1;
      end
    join
    idle(1);
    for (int i = 0; i < 6; i++) expect_rd(pat(9'(i % 2)));
    idle(3);
    check(DW'(rd_valid), '0);
  endtask
  task automatic t_sleep();
    sleep <= 1'b1;
    idle(4);
    check(DW'(asleep), DW'(1));
    req(1'b1, 1'b0, AW'(0), '1, pat(9'h77));
    idle(4);
    sleep <= 1'b0;
    idle(4);
    check(DW'(asleep), '0);
    req(1'b0, 1'b0, AW'(0), '0, '0);
    idle(1);
    expect_rd(pat(9'h0));
  endtask
  task automatic t_oe();
    out_disable <= 1'b1;
    idle(3);
    req(1'b0, 1'b0, AW'(1), '0, '0);
    idle(1);
    expect_rd('0);
    out_disable <= 1'b0;
    idle(3);
    req(1'b0, 1'b0, AW'(1), '0, '0);
    idle(1);
    expect_rd(pat(9'h1));
  endtask
  // tms changes with the falling tck, well before the rise samples it
  task automatic tap_step(input logic m);
    tms <= m;
    tck <= 1'b0;
    repeat (8) @(posedge clk);
    tck <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_tap();
    logic [31:0] id;
    for (int i = 0; i < 4; i++) tap_step(i == 1);
    for (int i = 0; i < 32; i++) begin
      tap_step(1'b0);
      id[i] = tdo;
    end
    check(DW'(id), DW'(ID));
    check(DW'(pbsc_bus.tap_tdo_oe), DW'(1));
  endtask
  task automatic complete_run();
    $display("checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_burst = 1'b0;
    req_addr = '0;
    req_lanes = '0;
    req_wdata = '0;
    rd_ready = 1'b1;
    sleep = 1'b0;
    out_disable = 1'b0;
    interleave = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_b2b();
    t_lanes();
    t_burst(1'b0);
    t_burst(1'b1);
    t_stall();
    t_sleep();
    t_oe();
    t_tap();
    complete_run();
  end
endmodule // tb
